// file: inc/mbs_consts.vh
`ifndef MBS_CONSTS_VH
`define MBS_CONSTS_VH

// ----------------------------------------------------------------
// link timing
// ----------------------------------------------------------------
`define MBS_CLK_NS        5
// one character: 10 bits at 9600 bit/s, in ns
`define MBS_CHAR_NS       1041667
// least gap, in half characters (3.5 chars)
`define MBS_MIN_GAP_HALF  9'h007

// ----------------------------------------------------------------
// frame layout (byte positions)
// ----------------------------------------------------------------
`define MBS_POS_SLAVE     5'h00
`define MBS_POS_CMD       5'h01
`define MBS_POS_ADDR_HI   5'h02
`define MBS_POS_ADDR_LO   5'h03
`define MBS_POS_CNT_HI    5'h04
`define MBS_POS_CNT_LO    5'h05
`define MBS_POS_BCNT      5'h06
`define MBS_POS_MDATA     5'h07
`define MBS_BUF_DEPTH     6'h20
`define MBS_MIN_FRAME     6'h04
`define MBS_SINGLE_LEN    6'h08
`define MBS_MULTI_BASE    6'h09
`define MBS_MAX_REGS      16'h000a

// ----------------------------------------------------------------
// commands, addresses, exceptions
// ----------------------------------------------------------------
`define MBS_CMD_READ      8'h03
`define MBS_CMD_WR_SAVE   8'h06
`define MBS_CMD_WR_TEMP   8'h07
`define MBS_CMD_WR_MULTI  8'h10
`define MBS_ERR_FLAG      8'h80
`define MBS_BROADCAST     8'h00
`define MBS_GRP_CTRL      8'h64
`define MBS_GRP_STAT      8'h65
`define MBS_EXC_NONE      8'h00
`define MBS_EXC_CMD       8'h02
`define MBS_EXC_CRC       8'h03
`define MBS_EXC_ADDR      8'h04
`define MBS_EXC_PARAM     8'h05
`define MBS_EXC_CHANGE    8'h06

// ----------------------------------------------------------------
// check sum
// ----------------------------------------------------------------
`define MBS_CRC_INIT      16'hffff
`define MBS_CRC_POLY      16'ha001

`endif

// file: rtl/mbs_crc16.v
`timescale 1ns/1ps
`include "mbs_consts.vh"

// ----------------------------------------------------------------
// one byte step of the reflected check sum
// ----------------------------------------------------------------
module mbs_crc16 (
   input  wire [15:0] crc_in,
   input  wire [7:0]  data,
   output wire [15:0] crc_out
);

   function [15:0] crc_step;
      input [15:0] c;
      input [7:0]  d;
      reg   [15:0] t;
      integer      i;
      begin
         t = c ^ {8'h00, d};
         for (i = 0; i < 8; i = i + 1) begin
            if (t[0]) begin
               t = (t >> 1) ^ `MBS_CRC_POLY;
            end else begin
               t = t >> 1;
            end
         end
         crc_step = t;
      end
   endfunction

   assign crc_out = crc_step(crc_in, data);

endmodule

// file: rtl/mbs_slave.v
// Notes on behaviour
// - multi-byte fields travel high byte first
// - frames delimited by at least 3.5 char silence
// - idle gap is max of setting and 3.5
// - one gap between frames is enough
// - check sum over frame, low byte sent first
// - response delay never below 3.5 chars
// - command 03 reads consecutive parameters
// - command 06 writes one parameter, saved
// - command 07 writes one parameter, not saved
// - command 10 writes several parameters, saved
// - address high byte group, low byte index
// - only listed groups 00 to 63 valid
// - control group 64, status group 65
// - control word one sits at 6400
// - read answer: command, byte count, data
// - failure answer: command plus 80, cause
// - broadcast requests get no answer
// - link defaults 9600 baud, 8N1, RTU
// - causes: 02 command, 03 check, 04 address
// - multi write count 1..10, bytes twice that
`timescale 1ns/1ps
`include "mbs_consts.vh"

module mbs_slave #(
   parameter [19:0] HALF_CHAR_CYCLES =
      (`MBS_CHAR_NS + 2 * `MBS_CLK_NS - 1) / (2 * `MBS_CLK_NS)
) (
   input  wire        clock,
   input  wire        rst_n,
   input  wire        rx_valid,
   input  wire [7:0]  rx_data,
   input  wire [7:0]  cfg_slave_addr,
   input  wire [7:0]  cfg_idle_half,
   input  wire [7:0]  cfg_resp_half,
   output reg         par_req,
   output reg  [15:0] par_addr,
   output reg  [15:0] par_wdata,
   output reg         par_write,
   output reg         par_persist,
   input  wire [15:0] par_rdata,
   input  wire        par_ack,
   input  wire [7:0]  par_exc,
   output reg         tx_valid,
   output reg  [7:0]  tx_data,
   input  wire        tx_ready,
   output reg         tx_en
);

   // ----------------------------------------------------------------
   // states
   // ----------------------------------------------------------------
   localparam [5:0] ST_RX     = 6'h01;
   localparam [5:0] ST_CHECK  = 6'h02;
   localparam [5:0] ST_ACCESS = 6'h04;
   localparam [5:0] ST_WAIT   = 6'h08;
   localparam [5:0] ST_SEND   = 6'h10;
   localparam [5:0] ST_DONE   = 6'h20;

   // ----------------------------------------------------------------
   // decoding
   // ----------------------------------------------------------------
   function group_ok;
      input [7:0] g;
      begin
         case (g)
            8'h12, 8'h13, 8'h19: group_ok = 1'b0;
            8'h1a, 8'h28, 8'h29, 8'h2a, 8'h2b, 8'h32, 8'h58,
            8'h61, 8'h62, 8'h63, `MBS_GRP_CTRL, `MBS_GRP_STAT: group_ok = 1'b1;
            default: group_ok = (g <= 8'h18);
         endcase
      end
   endfunction

   function [8:0] at_least_min;
      input [7:0] v;
      begin
         if ({1'b0, v} > `MBS_MIN_GAP_HALF) begin
            at_least_min = {1'b0, v};
         end else begin
            at_least_min = `MBS_MIN_GAP_HALF;
         end
      end
   endfunction

   // ----------------------------------------------------------------
   // storage and state
   // ----------------------------------------------------------------
   reg  [7:0]  mem [0:31];
   reg  [5:0]  state;
   reg  [5:0]  len;
   reg         ovf;
   reg  [15:0] rx_crc;
   reg  [15:0] tx_crc;
   reg  [19:0] half_cnt;
   reg  [8:0]  gap_cnt;
   reg  [7:0]  cmd;
   reg  [15:0] start_addr;
   reg  [3:0]  nregs;
   reg  [3:0]  idx;
   reg         pend;
   reg         bcast;
   reg  [5:0]  resp_len;
   reg  [4:0]  tx_ptr;
   reg  [1:0]  tx_phase;
   reg         skid_v;
   reg  [7:0]  skid_d;

   wire        half_tick  = (half_cnt == HALF_CHAR_CYCLES - 20'h00001);
   wire [8:0]  idle_thr   = at_least_min(cfg_idle_half);
   wire [8:0]  resp_thr   = at_least_min(cfg_resp_half);
   wire        line_quiet = (gap_cnt >= idle_thr);
   wire        gap_clear  = (state == ST_RX && rx_valid) || (state == ST_ACCESS);
   wire [15:0] rx_crc_in  = (len == 6'h00) ? `MBS_CRC_INIT : rx_crc;
   wire [15:0] rx_crc_next;
   wire [15:0] tx_crc_next;

   // ----------------------------------------------------------------
   // request fields
   // ----------------------------------------------------------------
   wire [7:0]  f_cmd   = mem[`MBS_POS_CMD];
   wire [15:0] f_addr  = {mem[`MBS_POS_ADDR_HI], mem[`MBS_POS_ADDR_LO]};
   wire [15:0] f_cnt   = {mem[`MBS_POS_CNT_HI], mem[`MBS_POS_CNT_LO]};
   wire [7:0]  f_bcnt  = mem[`MBS_POS_BCNT];
   wire        is_rd   = (f_cmd == `MBS_CMD_READ);
   wire        is_one  = (f_cmd == `MBS_CMD_WR_SAVE) || (f_cmd == `MBS_CMD_WR_TEMP);
   wire        is_mul  = (f_cmd == `MBS_CMD_WR_MULTI);
   wire [15:0] f_n     = is_one ? 16'h0001 : f_cnt;
   wire [15:0] f_end   = f_addr + f_n - 16'h0001;
   wire        cnt_bad = (f_n == 16'h0000) || (f_n > `MBS_MAX_REGS);
   wire [5:0]  mul_len = `MBS_MULTI_BASE + f_bcnt[5:0];
   wire        to_me   = (mem[`MBS_POS_SLAVE] == cfg_slave_addr) ||
                         (mem[`MBS_POS_SLAVE] == `MBS_BROADCAST);
   reg  [7:0]  chk_exc;

   always @* begin
      chk_exc = `MBS_EXC_NONE;
      if (rx_crc != 16'h0000) begin
         chk_exc = `MBS_EXC_CRC;
      end else if (!(is_rd || is_one || is_mul)) begin
         chk_exc = `MBS_EXC_CMD;
      end else if (cnt_bad || (!is_mul && len != `MBS_SINGLE_LEN)) begin
         chk_exc = `MBS_EXC_PARAM;
      end else if (is_mul && ({8'h00, f_bcnt} != {f_cnt[14:0], 1'b0} ||
                              len != mul_len)) begin
         chk_exc = `MBS_EXC_PARAM;
      end else if (!group_ok(f_addr[15:8]) || f_end[15:8] != f_addr[15:8]) begin
         chk_exc = `MBS_EXC_ADDR;
      end else if (!is_rd && f_addr[15:8] == `MBS_GRP_STAT) begin
         chk_exc = `MBS_EXC_CHANGE;
      end
   end

   // ----------------------------------------------------------------
   // transmit source
   // ----------------------------------------------------------------
   wire       push    = (state == ST_SEND) && !skid_v;
   reg  [7:0] push_d;

   always @* begin
      case (tx_phase)
         2'd0:    push_d = mem[tx_ptr];
         2'd1:    push_d = tx_crc[7:0];
         default: push_d = tx_crc[15:8];
      endcase
   end

   mbs_crc16 u_rx_crc (
      .crc_in  (rx_crc_in),
      .data    (rx_data),
      .crc_out (rx_crc_next)
   );

   mbs_crc16 u_tx_crc (
      .crc_in  (tx_crc),
      .data    (push_d),
      .crc_out (tx_crc_next)
   );

   // ----------------------------------------------------------------
   // silence timing
   // ----------------------------------------------------------------
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         half_cnt <= 20'h00000;
         gap_cnt  <= 9'h000;
      end else if (gap_clear) begin
         half_cnt <= 20'h00000;
         gap_cnt  <= 9'h000;
      end else if (half_tick) begin
         half_cnt <= 20'h00000;
         if (gap_cnt != 9'h1ff) begin
            gap_cnt <= gap_cnt + 9'h001;
         end
      end else begin
         half_cnt <= half_cnt + 20'h00001;
      end
   end

   // ----------------------------------------------------------------
   // two-entry output buffer
   // ----------------------------------------------------------------
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         tx_valid <= 1'b0;
         tx_data  <= 8'h00;
         skid_v   <= 1'b0;
         skid_d   <= 8'h00;
      end else if (!tx_valid || tx_ready) begin
         if (skid_v) begin
            tx_data <= skid_d;
            skid_v  <= 1'b0;
         end else begin
            tx_valid <= push;
            if (push) begin
               tx_data <= push_d;
            end
         end
      end else if (push) begin
         skid_v <= 1'b1;
         skid_d <= push_d;
      end
   end

   // ----------------------------------------------------------------
   // frame handling
   // ----------------------------------------------------------------
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state       <= ST_RX;
         len         <= 6'h00;
         ovf         <= 1'b0;
         rx_crc      <= `MBS_CRC_INIT;
         tx_crc      <= `MBS_CRC_INIT;
         cmd         <= 8'h00;
         start_addr  <= 16'h0000;
         nregs       <= 4'h0;
         idx         <= 4'h0;
         pend        <= 1'b0;
         bcast       <= 1'b0;
         resp_len    <= 6'h00;
         tx_ptr      <= 5'h00;
         tx_phase    <= 2'd0;
         tx_en       <= 1'b0;
         par_req     <= 1'b0;
         par_addr    <= 16'h0000;
         par_wdata   <= 16'h0000;
         par_write   <= 1'b0;
         par_persist <= 1'b0;
      end else begin
         par_req <= 1'b0;
         case (state)
            ST_RX: begin
               if (rx_valid && (len != 6'h00 || line_quiet)) begin
                  rx_crc <= rx_crc_next;
                  if (len == `MBS_BUF_DEPTH) begin
                     ovf <= 1'b1;
                  end else begin
                     mem[len[4:0]] <= rx_data;
                     len           <= len + 6'h01;
                  end
               end else if (len != 6'h00 && line_quiet) begin
                  state <= ST_CHECK;
               end
            end
            ST_CHECK: begin
               cmd        <= f_cmd;
               start_addr <= f_addr;
               nregs      <= f_n[3:0];
               idx        <= 4'h0;
               pend       <= 1'b0;
               bcast      <= (mem[`MBS_POS_SLAVE] == `MBS_BROADCAST);
               if (len < `MBS_MIN_FRAME || ovf || !to_me) begin
                  state <= ST_RX;
                  len   <= 6'h00;
                  ovf   <= 1'b0;
               end else if (chk_exc != `MBS_EXC_NONE) begin
                  mem[`MBS_POS_CMD]     <= f_cmd | `MBS_ERR_FLAG;
                  mem[`MBS_POS_ADDR_HI] <= chk_exc;
                  resp_len              <= 6'h03;
                  if (mem[`MBS_POS_SLAVE] == `MBS_BROADCAST) begin
                     state <= ST_RX;
                     len   <= 6'h00;
                  end else begin
                     state <= ST_WAIT;
                  end
               end else begin
                  state <= ST_ACCESS;
               end
            end
            ST_ACCESS: begin
               if (!pend) begin
                  pend        <= 1'b1;
                  par_req     <= 1'b1;
                  par_addr    <= start_addr + {12'h000, idx};
                  par_write   <= (cmd != `MBS_CMD_READ);
                  par_persist <= (cmd != `MBS_CMD_WR_TEMP);
                  if (cmd == `MBS_CMD_WR_MULTI) begin
                     par_wdata <= {mem[`MBS_POS_MDATA + {idx, 1'b0}],
                                   mem[`MBS_POS_MDATA + {idx, 1'b0} + 5'h01]};
                  end else begin
                     par_wdata <= {mem[`MBS_POS_CNT_HI], mem[`MBS_POS_CNT_LO]};
                  end
               end else if (par_ack) begin
                  pend <= 1'b0;
                  if (par_exc != `MBS_EXC_NONE) begin
                     mem[`MBS_POS_CMD]     <= cmd | `MBS_ERR_FLAG;
                     mem[`MBS_POS_ADDR_HI] <= par_exc;
                     resp_len              <= 6'h03;
                     state                 <= bcast ? ST_RX : ST_WAIT;
                     len                   <= bcast ? 6'h00 : len;
                  end else begin
                     if (cmd == `MBS_CMD_READ) begin
                        mem[`MBS_POS_ADDR_LO + {idx, 1'b0}]         <= par_rdata[15:8];
                        mem[`MBS_POS_ADDR_LO + {idx, 1'b0} + 5'h01] <= par_rdata[7:0];
                     end
                     idx <= idx + 4'h1;
                     if (idx == nregs - 4'h1) begin
                        if (cmd == `MBS_CMD_READ) begin
                           mem[`MBS_POS_ADDR_HI] <= {3'h0, nregs, 1'b0};
                           resp_len <= 6'h03 + {1'b0, nregs, 1'b0};
                        end else begin
                           resp_len <= len - 6'h02;
                        end
                        state <= bcast ? ST_RX : ST_WAIT;
                        len   <= bcast ? 6'h00 : len;
                     end
                  end
               end
            end
            ST_WAIT: begin
               if (gap_cnt >= resp_thr) begin
                  state    <= ST_SEND;
                  tx_en    <= 1'b1;
                  tx_ptr   <= 5'h00;
                  tx_phase <= 2'd0;
                  tx_crc   <= `MBS_CRC_INIT;
               end
            end
            ST_SEND: begin
               if (push) begin
                  if (tx_phase == 2'd0) begin
                     tx_crc <= tx_crc_next;
                     tx_ptr <= tx_ptr + 5'h01;
                     if ({1'b0, tx_ptr} == resp_len - 6'h01) begin
                        tx_phase <= 2'd1;
                     end
                  end else if (tx_phase == 2'd1) begin
                     tx_phase <= 2'd2;
                  end else begin
                     state <= ST_DONE;
                  end
               end
            end
            ST_DONE: begin
               if (!tx_valid && !skid_v) begin
                  tx_en <= 1'b0;
                  state <= ST_RX;
                  len   <= 6'h00;
                  ovf   <= 1'b0;
               end
            end
            default: begin
               state <= ST_RX;
               len   <= 6'h00;
            end
         endcase
      end
   end

endmodule

// file: testbench/mbs_master.sv
`timescale 1ns/1ps
module mbs_master #(
   parameter int HALF = 4
) (
   input  wire        clock,
   output logic       rx_valid,
   output logic [7:0] rx_data,
   input  wire        tx_valid,
   input  wire  [7:0] tx_data,
   output logic       tx_ready,
   input  wire        tx_en
);
   integer     seed = 32'hb30f6158;
   logic [7:0] got[$];
   int         ends = 0;
   bit         stall = 1'b0;
   integer     r;

   initial begin
      rx_valid = 1'b0;
      rx_data = 8'h00;
      tx_ready = 1'b1;
   end

   function automatic logic [15:0] crc16(input logic [7:0] q[$]);
      logic [15:0] c;
      c = 16'hffff;
      foreach (q[i]) begin
         c = c ^ {8'h00, q[i]};
         repeat (8) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
      end
      return c;
   endfunction

   // ---------------
   // request side: one byte per character time
   // ---------------
   task automatic send(input logic [7:0] f[$], input bit bad);
      logic [15:0] c;
      c = crc16(f) ^ {15'h0, bad};
      f.push_back(c[7:0]);
      f.push_back(c[15:8]);
      foreach (f[i]) begin
         @(negedge clock);
         rx_valid = 1'b1;
         rx_data = f[i];
         @(negedge clock);
         rx_valid = 1'b0;
         rx_data = ~f[i];
         repeat (2 * HALF - 2) @(negedge clock);
      end
   endtask

   // ---------------
   // answer side: optional random stall
   // ---------------
   always @(negedge clock) begin
      r = $random(seed);
      tx_ready <= !stall || r[0];
   end

   always @(posedge clock) begin
      if (tx_valid === 1'b1 && tx_ready === 1'b1)
         got.push_back(tx_data);
   end

   always @(negedge tx_en) ends = ends + 1;
endmodule

// file: testbench/mbs_slave_asserts.sv
`timescale 1ns/1ps
module mbs_slave_asserts #(
   parameter [19:0] HALF_CHAR_CYCLES = 20'd4
) (
   input wire        clock,
   input wire        rst_n,
   input wire        rx_valid,
   input wire        par_req,
   input wire [15:0] par_addr,
   input wire [15:0] par_wdata,
   input wire        par_write,
   input wire        par_persist,
   input wire        par_ack,
   input wire        tx_valid,
   input wire [7:0]  tx_data,
   input wire        tx_ready,
   input wire        tx_en
);
   // least silence, one tick of slack per counted gap
   localparam int REQ_MIN  = 6 * HALF_CHAR_CYCLES;
   localparam int RESP_MIN = 6 * HALF_CHAR_CYCLES;
   logic [31:0] quiet;
   logic        pend;

   // ---------------
   // helper state
   // ---------------
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         quiet <= 32'h0;
         pend <= 1'b0;
      end else begin
         quiet <= rx_valid ? 32'h0 : quiet + 32'h1;
         pend <= par_req | (pend & ~par_ack);
      end
   end

   default clocking dc @(posedge clock);
   endclocking
   default disable iff (!rst_n);

   // ---------------
   // checks
   // ---------------
   chk_req_after_gap:
   assert property (par_req |-> quiet >= REQ_MIN) else $error("request before frame gap");
   chk_resp_delay:
   assert property ($rose(tx_en) |-> quiet >= RESP_MIN) else $error("answer too early");
   chk_tx_hold:
   assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
      else $error("stalled byte changed");
   chk_valid_in_en:
   assert property (tx_valid |-> tx_en) else $error("byte offered outside answer");
   chk_en_fall:
   assert property ($fell(tx_en) |-> $past(tx_valid && tx_ready, 2))
      else $error("driver enable fell without last byte");
   chk_first_byte:
   assert property ($rose(tx_en) |-> ##[0:4] tx_valid) else $error("answer without byte");
   chk_req_pulse:
   assert property (par_req |=> !par_req) else $error("request longer than one cycle");
   chk_one_req:
   assert property (par_req |-> !pend) else $error("second request outstanding");
   chk_fields_hold:
   assert property (!par_req |-> $stable(par_addr) && $stable(par_wdata) && $stable(par_write))
      else $error("access fields moved");
   chk_no_tx_busy:
   assert property (pend |-> !tx_en) else $error("answer during access");

   cov_stall: cover property (tx_valid && !tx_ready);
   cov_volatile: cover property (par_req && par_write && !par_persist);
   cov_answer_end: cover property ($fell(tx_en));
   cov_read: cover property (par_req && !par_write);
endmodule

// file: testbench/tb.sv
`timescale 1ns/1ps
module tb;
   localparam int HALF = 4;
   logic        clock = 1'b0;
   logic        rst_n = 1'b0;
   logic [7:0]  cfg_slave_addr = 8'h05;
   logic [7:0]  cfg_idle_half = 8'h03;
   logic [7:0]  cfg_resp_half = 8'h03;
   logic [15:0] par_rdata = 16'h0;
   logic        par_ack = 1'b0;
   logic [7:0]  par_exc = 8'h00;
   wire         par_req, par_write, par_persist, rx_valid, tx_valid, tx_ready, tx_en;
   wire  [15:0] par_addr, par_wdata;
   wire  [7:0]  rx_data, tx_data;
   int          n_mismatch = 0;
   int          check_count = 0;
   int          lat = 0;
   logic [15:0] mem [int];
   logic [33:0] acc [$];
   logic [15:0] exc_at = 16'hffff;
   logic [7:0]  exc_code = 8'h00;

   always #2.5 clock = ~clock;

   mbs_slave #(.HALF_CHAR_CYCLES(20'(HALF))) dut (
      .clock(clock), .rst_n(rst_n), .rx_valid(rx_valid), .rx_data(rx_data),
      .cfg_slave_addr(cfg_slave_addr), .cfg_idle_half(cfg_idle_half),
      .cfg_resp_half(cfg_resp_half), .par_req(par_req), .par_addr(par_addr),
      .par_wdata(par_wdata), .par_write(par_write), .par_persist(par_persist),
      .par_rdata(par_rdata), .par_ack(par_ack), .par_exc(par_exc),
      .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .tx_en(tx_en));
   mbs_master #(.HALF(HALF)) m (
      .clock(clock), .rx_valid(rx_valid), .rx_data(rx_data), .tx_valid(tx_valid),
      .tx_data(tx_data), .tx_ready(tx_ready), .tx_en(tx_en));

   // parameter store, answers 1..4 cycles after a request
   always @(negedge clock) begin
      par_ack <= 1'b0;
      if (lat > 0) begin
         lat = lat - 1;
         if (lat == 0) begin
            par_ack <= 1'b1;
            par_exc <= (par_addr == exc_at) ? exc_code : 8'h00;
            par_rdata <= mem.exists(par_addr) ? mem[par_addr] : 16'h0;
            if (par_write && par_addr != exc_at)
               mem[par_addr] = par_wdata;
         end
      end
      if (par_req === 1'b1) begin
         acc.push_back({par_write, par_persist, par_addr, par_wdata});
         lat = 1 + ($random(m.seed) & 3);
      end
   end

   task automatic check(input string what, input logic [33:0] e, input logic [33:0] g);
      check_count++;
      if (g !== e) begin
         n_mismatch++;
         $display("unexpected %s: expected %h seen %h", what, e, g);
      end
   endtask

   task automatic end_of_test;
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic check_resp(input logic [7:0] e[$]);
      logic [15:0] c;
      int i;
      c = m.crc16(e);
      e.push_back(c[7:0]);
      e.push_back(c[15:8]);
      i = 0;
      while (m.ends == 0) begin
         @(negedge clock);
         i++;
         if (i == 5000) begin
            n_mismatch++;
            end_of_test;
         end
      end
      check("length", e.size(), m.got.size());
      foreach (e[k])
         check("byte", e[k], m.got[k]);
      m.got.delete();
      m.ends = 0;
      repeat (8 * HALF) @(negedge clock);
   endtask

   task automatic check_none;
      repeat (400) @(negedge clock);
      check("silence", 34'd0, m.got.size());
   endtask

   task automatic check_acc(input logic w, input logic p, input logic [15:0] a,
                            input logic [15:0] d);
      logic [33:0] g;
      g = 34'hx;
      if (acc.size() > 0)
         g = acc.pop_front();
      if (!w)
         g = {g[33], p, g[31:16], d};
      check("access", {w, p, a, d}, g);
   endtask

   initial begin
      logic [7:0]  f[$];
      logic [7:0]  e[$];
      logic [15:0] v;
      logic [63:0] tbl[7];
      int          i;
      // frame bytes, expected cause, corrupt check sum
      tbl = '{64'h050300010000_0500, 64'h05030001000b_0500, 64'h050400010001_0200,
              64'h050301010001_0301, 64'h050312000001_0400, 64'h050366000001_0400,
              64'h050665000001_0600};
      repeat (3) @(negedge clock);
      rst_n = 1'b1;
      repeat (8 * HALF) @(negedge clock);
      m.ends = 0;
      check("model_sum", 16'hb2d5, m.crc16('{8'h05, 8'h03, 8'h01, 8'h01, 8'h00, 8'h01}));
      mem[16'h0101] = 16'h1388;
      m.send('{8'h05, 8'h03, 8'h01, 8'h01, 8'h00, 8'h01}, 1'b0);
      check_resp('{8'h05, 8'h03, 8'h02, 8'h13, 8'h88});
      check_acc(1'b0, 1'b0, 16'h0101, 16'h0);
      $display("test single read done");
      e = '{8'h05, 8'h03, 8'h14};
      for (i = 0; i < 10; i++) begin
         v = $random(m.seed);
         mem[16'h6400 + i] = v;
         e.push_back(v[15:8]);
         e.push_back(v[7:0]);
      end
      m.stall = 1'b1;
      m.send('{8'h05, 8'h03, 8'h64, 8'h00, 8'h00, 8'h0a}, 1'b0);
      check_resp(e);
      for (i = 0; i < 10; i++)
         check_acc(1'b0, 1'b0, 16'(16'h6400 + i), 16'h0);
      m.stall = 1'b0;
      $display("test ten reads with stall done");
      for (i = 0; i < 7; i++) begin
         f = '{tbl[i][63:56], tbl[i][55:48], tbl[i][47:40],
               tbl[i][39:32], tbl[i][31:24], tbl[i][23:16]};
         m.send(f, tbl[i][0]);
         check_resp('{8'h05, tbl[i][55:48] | 8'h80, tbl[i][15:8]});
      end
      check("stray_access", 34'd0, acc.size());
      $display("test exceptions done");
      for (i = 0; i < 2; i++) begin
         v = $random(m.seed);
         f = '{8'h05, 8'h06 + i[7:0], 8'h03, 8'h02, v[15:8], v[7:0]};
         m.send(f, 1'b0);
         check_resp(f);
         check_acc(1'b1, i == 0, 16'h0302, v);
      end
      $display("test single writes done");
      f = '{8'h05, 8'h10, 8'h64, 8'h01, 8'h00, 8'h03, 8'h06};
      for (i = 0; i < 6; i++) begin
         v = $random(m.seed);
         f.push_back(v[7:0]);
      end
      m.send(f, 1'b0);
      check_resp(f);
      for (i = 0; i < 3; i++)
         check_acc(1'b1, 1'b1, 16'(16'h6401 + i), {f[7 + 2 * i], f[8 + 2 * i]});
      exc_at = 16'h6402;
      exc_code = 8'h08;
      m.send(f, 1'b0);
      check_resp('{8'h05, 8'h90, 8'h08});
      for (i = 0; i < 2; i++)
         check_acc(1'b1, 1'b1, 16'(16'h6401 + i), {f[7 + 2 * i], f[8 + 2 * i]});
      check("abort_access", 34'd0, acc.size());
      exc_at = 16'hffff;
      $display("test multiple write done");
      m.send('{8'h00, 8'h06, 8'h03, 8'h05, 8'h12, 8'h34}, 1'b0);
      check_none;
      check_acc(1'b1, 1'b1, 16'h0305, 16'h1234);
      m.send('{8'h09, 8'h06, 8'h03, 8'h05, 8'h12, 8'h34}, 1'b0);
      check_none;
      check("other_access", 34'd0, acc.size());
      $display("test broadcast and other station done");
      cfg_resp_half = 8'h14;
      for (i = 0; i < 2; i++) begin
         cfg_idle_half = i ? 8'h03 : 8'h0a;
         m.send('{8'h77}, 1'b0);
         repeat (6 * HALF) @(negedge clock);
         m.send('{8'h05, 8'h03, 8'h01, 8'h01, 8'h00, 8'h01}, 1'b0);
         if (i) begin
            repeat (20 * HALF) @(negedge clock);
            check("resp_delay", 34'd0, m.got.size());
            check_resp('{8'h05, 8'h03, 8'h02, 8'h13, 8'h88});
         end else begin
            check_none;
         end
      end
      check_acc(1'b0, 1'b0, 16'h0101, 16'h0);
      $display("test idle setting done");
      end_of_test;
   end
endmodule

bind mbs_slave mbs_slave_asserts #(.HALF_CHAR_CYCLES(HALF_CHAR_CYCLES)) chk (
   .clock(clock), .rst_n(rst_n), .rx_valid(rx_valid), .par_req(par_req),
   .par_addr(par_addr), .par_wdata(par_wdata), .par_write(par_write),
   .par_persist(par_persist), .par_ack(par_ack), .tx_valid(tx_valid),
   .tx_data(tx_data), .tx_ready(tx_ready), .tx_en(tx_en));
